//--- io_expander_pkg.sv
// constants, register map and bus states of the 16-bit port expander logic
// assumes a single 10 MHz core clock and a synchronous active-low reset
// Notes on behaviour
// - pull-up on only for set bit and input pin
// - flag bit marks each enabled pin that interrupted
// - flag register read-only, writes ignored
// - capture loads on interrupt, holds until cleared
// - port read returns sampled pin levels
// - port write updates the output latch
// - latch read returns latch contents, not pins
// - latch drives pins configured as outputs
// - per-pin enable and selectable compare source
// - independent interrupt per port, cleared by read
// - mirror clear routes each port to own output
// - mirror set ORs both; each read clears own
// - pin-change mode compares enabled pins to previous
// - default mode compares enabled pins to default
// - output style push-pull low, high or open-drain
// - only enabled input pins raise interrupts
// - writes never clear a pending interrupt
// - clear only once read data is delivered
// - first event captures; later ones wait for clear
// - pending change re-raises and recaptures after clear
// - after clear, captured level becomes new reference
// - default mismatch re-raises interrupt one cycle after clear
// - open-drain overrides polarity setting
// - control bit zero means compare to previous
package io_expander_pkg;

  // sizes
  localparam int PORT_COUNT = 2;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // register indices within one port; byte address is four times the index
  localparam logic [3:0] IDX_DIRECTION = 4'h0;
  localparam logic [3:0] IDX_CHG_EN    = 4'h2;
  localparam logic [3:0] IDX_DEFAULT   = 4'h3;
  localparam logic [3:0] IDX_SRC_SEL   = 4'h4;
  localparam logic [3:0] IDX_CONFIG    = 4'h5;
  localparam logic [3:0] IDX_PULLUP    = 4'h6;
  localparam logic [3:0] IDX_FLAGS     = 4'h7;
  localparam logic [3:0] IDX_CAPTURE   = 4'h8;
  localparam logic [3:0] IDX_PORT      = 4'h9;
  localparam logic [3:0] IDX_LATCH     = 4'hA;

  // index bit that selects port b (port b block starts at index 0x10)
  localparam int PORT_SEL_BIT = 4;

  // device_config fields
  localparam int         CFG_MIRROR_BIT = 6;
  localparam int         CFG_ODR_BIT    = 2;
  localparam int         CFG_POL_BIT    = 1;
  localparam logic [7:0] CFG_WMASK      = 8'hFE;

  // reset values
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_CAPTURE   = 8'h00;

  // register bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

//--- io_expander_port_irq_logic.sv
// per-port registers and interrupt-on-change logic of a 16-bit i/o expander
// assumes avalon-mm master on CORE_CLK, pins asynchronous to it, pads resolved outside
`timescale 1ns/1ps
module io_expander_port_irq_logic
  import io_expander_pkg::*;
(
  // clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_N,
  // avalon-mm register slave
  input  wire logic [ADDR_WIDTH-1:0] AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [DATA_WIDTH-1:0] AVS_WRITEDATA,
  output logic      [DATA_WIDTH-1:0] AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  // port a pins
  input  wire logic [PORT_WIDTH-1:0] PA_IN,
  output logic      [PORT_WIDTH-1:0] PA_OUT,
  output logic      [PORT_WIDTH-1:0] PA_OE,
  output logic      [PORT_WIDTH-1:0] PA_PULLUP,
  // port b pins
  input  wire logic [PORT_WIDTH-1:0] PB_IN,
  output logic      [PORT_WIDTH-1:0] PB_OUT,
  output logic      [PORT_WIDTH-1:0] PB_OE,
  output logic      [PORT_WIDTH-1:0] PB_PULLUP,
  // interrupt outputs, open-drain capable
  output logic                       IRQ_OUT_A,
  output logic                       IRQ_OUT_A_OE,
  output logic                       IRQ_OUT_B,
  output logic                       IRQ_OUT_B_OE
);

  // decode of the in-port register index, shared by read and write paths
  function automatic logic reg_mapped(input logic [5:0] idx);
    logic [3:0] r;
    logic       in_bank;
    logic       in_range;
    r          = idx[3:0];
    in_bank    = (idx[5] == 1'b0);                     // only two banks of sixteen words
    in_range   = (r <= IDX_LATCH) && (r != 4'h1);      // word one of each bank is a hole
    reg_mapped = in_bank && in_range;
  endfunction

  // bus handshake
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic       bus_req;
  logic       accept;
  logic [5:0] word_idx;
  logic [3:0] reg_idx;
  logic       hit;
  logic       port_b;

  assign bus_req  = AVS_READ | AVS_WRITE;
  assign accept   = bus_req & (bus_state == BUS_ACK);
  assign word_idx = AVS_ADDRESS[7:2];
  assign reg_idx  = word_idx[3:0];
  assign hit      = reg_mapped(word_idx);
  assign port_b   = word_idx[PORT_SEL_BIT];

  // one-hot register select, decoded once and shared by both ports
  logic sel_direction;
  logic sel_chg_en;
  logic sel_default;
  logic sel_src_sel;
  logic sel_config;
  logic sel_pullup;
  logic sel_flags;
  logic sel_capture;
  logic sel_port;
  logic sel_latch;
  logic rd_accept;
  logic wr_accept;

  assign sel_direction = (reg_idx == IDX_DIRECTION);
  assign sel_chg_en    = (reg_idx == IDX_CHG_EN);
  assign sel_default   = (reg_idx == IDX_DEFAULT);
  assign sel_src_sel   = (reg_idx == IDX_SRC_SEL);
  assign sel_config    = (reg_idx == IDX_CONFIG);
  assign sel_pullup    = (reg_idx == IDX_PULLUP);
  assign sel_flags     = (reg_idx == IDX_FLAGS);
  assign sel_capture   = (reg_idx == IDX_CAPTURE);
  assign sel_port      = (reg_idx == IDX_PORT);
  assign sel_latch     = (reg_idx == IDX_LATCH);

  // accepted read and write, one cycle each; side effects belong to the
  // accepting edge only, never to the wait cycle
  assign rd_accept     = accept & AVS_READ;
  assign wr_accept     = accept & AVS_WRITE;

  // access timing: a request seen at edge 0 loads read data and drops
  // waitrequest; edge 1 is the accepting edge where writes land and reads
  // clear, and raises waitrequest again, so back-to-back requests are fine
  // one wait cycle per access, so read data is settled before it is taken
  always_comb begin
    case (bus_state)
      BUS_IDLE: next_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  next_bus_state = BUS_IDLE;
      default:  next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // shared configuration, one copy serves both ports
  logic [7:0] device_config;
  logic       wr_config;
  logic       mirror;
  logic       irq_open_drain;
  logic       irq_polarity;

  assign wr_config      = wr_accept & hit & sel_config;
  assign mirror         = device_config[CFG_MIRROR_BIT];
  assign irq_open_drain = device_config[CFG_ODR_BIT];
  assign irq_polarity   = device_config[CFG_POL_BIT];

  // shared configuration; bit 0 is not stored and reads as zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      device_config <= RST_ZERO;
    end else if (wr_config) begin
      device_config <= AVS_WRITEDATA[7:0] & CFG_WMASK;
    end
  end

  // per-port state, index 0 is port a and 1 is port b
  logic [PORT_WIDTH-1:0] pin_in        [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pin_direction [PORT_COUNT];
  logic [PORT_WIDTH-1:0] chg_irq_en    [PORT_COUNT];
  logic [PORT_WIDTH-1:0] cmp_default   [PORT_COUNT];
  logic [PORT_WIDTH-1:0] cmp_src_sel   [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pullup_bits   [PORT_COUNT];
  logic [PORT_WIDTH-1:0] flags         [PORT_COUNT];
  logic [PORT_WIDTH-1:0] captured_bits [PORT_COUNT];
  logic [PORT_WIDTH-1:0] latch_bits    [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pin_level     [PORT_COUNT];
  logic [PORT_WIDTH-1:0] reference     [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pin_out       [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pin_oe        [PORT_COUNT];
  logic [PORT_WIDTH-1:0] pin_pullup    [PORT_COUNT];
  logic [PORT_WIDTH-1:0] read_value    [PORT_COUNT];
  logic                  port_irq      [PORT_COUNT];

  assign pin_in[0] = PA_IN;
  assign pin_in[1] = PB_IN;

  // two identical port slices, a then b
  genvar p;
  generate
    for (p = 0; p < PORT_COUNT; p++) begin : g_port
      logic [PORT_WIDTH-1:0] sync1;
      logic [PORT_WIDTH-1:0] sync2;
      logic [PORT_WIDTH-1:0] sync3;
      logic                  sel;
      logic                  wr_hit;
      logic                  read_clear;
      logic [PORT_WIDTH-1:0] armed;
      logic [PORT_WIDTH-1:0] vs_previous;
      logic [PORT_WIDTH-1:0] vs_default;
      logic [PORT_WIDTH-1:0] mismatch;
      logic                  event_now;
      logic                  raise;
      logic [PORT_WIDTH-1:0] wdata;
      logic                  wr_direction;
      logic                  wr_chg_en;
      logic                  wr_default;
      logic                  wr_src_sel;
      logic                  wr_pullup;
      logic                  wr_latch;
      logic                  set_pending;
      logic [PORT_WIDTH-1:0] agree;
      logic [PORT_WIDTH-1:0] next_level;

      assign sel    = hit & (port_b == 1'(p));
      assign wr_hit = wr_accept & sel;
      assign wdata  = AVS_WRITEDATA[PORT_WIDTH-1:0];

      // per-register write strobes of this port
      assign wr_direction = wr_hit & sel_direction;
      assign wr_chg_en    = wr_hit & sel_chg_en;
      assign wr_default   = wr_hit & sel_default;
      assign wr_src_sel   = wr_hit & sel_src_sel;
      assign wr_pullup    = wr_hit & sel_pullup;
      // port and latch writes share the one latch; flags and capture have none
      assign wr_latch     = wr_hit & (sel_port | sel_latch);

      // reading port or capture clears only this port, at the accepting edge
      assign read_clear = rd_accept & sel & (sel_port | sel_capture);

      // only input pins with change enable take part
      assign armed       = chg_irq_en[p] & pin_direction[p];
      assign vs_previous = pin_level[p] ^ reference[p];
      assign vs_default  = pin_level[p] ^ cmp_default[p];
      // control bit zero picks previous value, one picks default
      assign mismatch    = armed & ((cmp_src_sel[p] & vs_default) | (~cmp_src_sel[p] & vs_previous));
      assign event_now   = |mismatch;
      // while pending, further events neither raise nor recapture
      assign raise       = event_now & ~port_irq[p];
      // a read on the raising edge wins; a standing default mismatch comes back next cycle
      assign set_pending = raise & ~read_clear;

      // a bit moves only when stages two and three agree, so a level that is
      // still settling in the first stage never reaches the compare logic
      assign agree      = ~(sync2 ^ sync3);
      assign next_level = (sync2 & agree) | (pin_level[p] & ~agree);

      // three-stage pin sampler; level moves once stages two and three agree
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          sync1        <= RST_ZERO;
          sync2        <= RST_ZERO;
          sync3        <= RST_ZERO;
          pin_level[p] <= RST_ZERO;
        end else begin
          sync1        <= pin_in[p];
          sync2        <= sync1;
          sync3        <= sync2;
          pin_level[p] <= next_level;
        end
      end

      // plain read/write configuration registers
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          pin_direction[p] <= RST_DIRECTION;
          chg_irq_en[p]    <= RST_ZERO;
          cmp_default[p]   <= RST_ZERO;
          cmp_src_sel[p]   <= RST_ZERO;
          pullup_bits[p]   <= RST_ZERO;
        end else begin
          if (wr_direction) pin_direction[p] <= wdata;
          if (wr_chg_en)    chg_irq_en[p]    <= wdata;
          if (wr_default)   cmp_default[p]   <= wdata;
          if (wr_src_sel)   cmp_src_sel[p]   <= wdata;
          if (wr_pullup)    pullup_bits[p]   <= wdata;
        end
      end

      // port and latch writes both land in the latch
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          latch_bits[p] <= RST_ZERO;
        end else if (wr_latch) begin
          latch_bits[p] <= wdata;
        end
      end

      // interrupt state; flag and capture registers have no write path
      // a clear and a new condition in one cycle: cleared now, raised again next cycle
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          port_irq[p]      <= 1'b0;
          flags[p]         <= RST_ZERO;
          captured_bits[p] <= RST_CAPTURE;
        end else if (read_clear) begin
          port_irq[p] <= 1'b0;
          flags[p]    <= RST_ZERO;
        end else if (set_pending) begin
          port_irq[p]      <= 1'b1;
          flags[p]         <= mismatch;
          captured_bits[p] <= pin_level[p];
        end
      end

      // reference follows the pins while idle, freezes while pending, and
      // restarts from the captured level so a change held across the clear re-raises
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          reference[p] <= RST_ZERO;
        end else if (read_clear) begin
          reference[p] <= captured_bits[p];
        end else if (!port_irq[p] && !raise) begin
          reference[p] <= pin_level[p];
        end
      end

      // pin drive, all registered
      // pads follow latch and direction one edge later
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          pin_out[p]    <= RST_ZERO;
          pin_oe[p]     <= RST_ZERO;
          pin_pullup[p] <= RST_ZERO;
        end else begin
          pin_out[p]    <= latch_bits[p];
          pin_oe[p]     <= ~pin_direction[p];
          pin_pullup[p] <= pullup_bits[p] & pin_direction[p];
        end
      end

      // read value of this port; latch reads the latch, port reads pins
      assign read_value[p] =
        (reg_idx == IDX_DIRECTION) ? pin_direction[p] :
        (reg_idx == IDX_CHG_EN)    ? chg_irq_en[p]    :
        (reg_idx == IDX_DEFAULT)   ? cmp_default[p]   :
        (reg_idx == IDX_SRC_SEL)   ? cmp_src_sel[p]   :
        (reg_idx == IDX_CONFIG)    ? device_config    :
        (reg_idx == IDX_PULLUP)    ? pullup_bits[p]   :
        (reg_idx == IDX_FLAGS)     ? flags[p]         :
        (reg_idx == IDX_CAPTURE)   ? captured_bits[p] :
        (reg_idx == IDX_PORT)      ? pin_level[p]     :
        (reg_idx == IDX_LATCH)     ? latch_bits[p]    : RST_ZERO;
    end
  endgenerate

  // read data is loaded in the wait cycle; unmapped words read as zero
  logic [DATA_WIDTH-1:0] next_readdata;
  logic                  rd_load;
  logic                  next_waitrequest;
  assign next_readdata    = hit ? {{(DATA_WIDTH-PORT_WIDTH){1'b0}}, read_value[port_b]} : '0;
  // loading one cycle early keeps the data path out of the accepting edge;
  // the cost is that a capture landing in the wait cycle is cleared unseen
  assign rd_load          = AVS_READ & (bus_state == BUS_IDLE);
  // low for exactly the one cycle that follows a new request
  assign next_waitrequest = ~(bus_req & (bus_state == BUS_IDLE));

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      AVS_READDATA    <= '0;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      if (rd_load) AVS_READDATA <= next_readdata;
      AVS_WAITREQUEST <= next_waitrequest;
    end
  end

  // output routing: separate or ORed
  // with mirroring on, both pads stay active until every pending port is read
  logic irq_any;
  logic irq_a_active;
  logic irq_b_active;
  assign irq_any      = port_irq[0] | port_irq[1];
  assign irq_a_active = mirror ? irq_any : port_irq[0];
  assign irq_b_active = mirror ? irq_any : port_irq[1];

  // pad value and enable of one interrupt output; open-drain only ever pulls
  // low and ignores polarity, push-pull always drives
  function automatic logic [1:0] irq_pad(input logic active, input logic open_drain, input logic active_high);
    logic [1:0] pad;
    if (open_drain) begin
      pad = {1'b0, active};
    end else begin
      pad = {(active_high ? active : ~active), 1'b1};
    end
    irq_pad = pad;
  endfunction

  logic [1:0] next_irq_a;
  logic [1:0] next_irq_b;
  assign next_irq_a = irq_pad(irq_a_active, irq_open_drain, irq_polarity);
  assign next_irq_b = irq_pad(irq_b_active, irq_open_drain, irq_polarity);

  // interrupt pad flops, released and low in reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      IRQ_OUT_A    <= 1'b0;
      IRQ_OUT_A_OE <= 1'b0;
      IRQ_OUT_B    <= 1'b0;
      IRQ_OUT_B_OE <= 1'b0;
    end else begin
      IRQ_OUT_A    <= next_irq_a[1];
      IRQ_OUT_A_OE <= next_irq_a[0];
      IRQ_OUT_B    <= next_irq_b[1];
      IRQ_OUT_B_OE <= next_irq_b[0];
    end
  end

  // pin outputs come straight from the drive flops
  assign PA_OUT    = pin_out[0];
  assign PA_OE     = pin_oe[0];
  assign PA_PULLUP = pin_pullup[0];
  assign PB_OUT    = pin_out[1];
  assign PB_OE     = pin_oe[1];
  assign PB_PULLUP = pin_pullup[1];

endmodule

//--- io_expander_port_irq_logic_assertions.sv
// port-level checks of the expander register bus, pads and interrupt outputs
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module io_expander_port_irq_logic_check
  import io_expander_pkg::*;
(
  // clock and reset
  input wire logic                  CORE_CLK,
  input wire logic                  RST_N,
  // bus
  input wire logic                  AVS_READ,
  input wire logic                  AVS_WRITE,
  input wire logic [DATA_WIDTH-1:0] AVS_READDATA,
  input wire logic                  AVS_WAITREQUEST,
  // pads
  input wire logic [PORT_WIDTH-1:0] PA_OUT,
  input wire logic [PORT_WIDTH-1:0] PA_OE,
  input wire logic [PORT_WIDTH-1:0] PA_PULLUP,
  input wire logic [PORT_WIDTH-1:0] PB_OE,
  input wire logic [PORT_WIDTH-1:0] PB_PULLUP,
  // interrupt outputs
  input wire logic                  IRQ_OUT_A,
  input wire logic                  IRQ_OUT_A_OE,
  input wire logic                  IRQ_OUT_B,
  input wire logic                  IRQ_OUT_B_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // bus requests and accepted writes
  wire req    = AVS_READ || AVS_WRITE;
  wire wr_acc = AVS_WRITE && !AVS_WAITREQUEST;

  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");
  AST_CAUSE: assert property (!AVS_WAITREQUEST |-> $past(req))
    else $error("waitrequest dropped without a request");
  AST_RD_UPPER: assert property (AVS_READDATA[31:8] == 24'h000000)
    else $error("read data above the register byte");
  AST_PU_A: assert property ((PA_PULLUP & PA_OE) == 8'h00)
    else $error("pull-up on a driven pin of port a");
  AST_PU_B: assert property ((PB_PULLUP & PB_OE) == 8'h00)
    else $error("pull-up on a driven pin of port b");
  AST_OUT_CAUSE: assert property ($changed(PA_OUT) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("port a output moved without a write");
  AST_OE_CAUSE: assert property ($changed(PA_OE) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("port a enable moved without a write");
  AST_OD_A: assert property (!IRQ_OUT_A_OE |-> !IRQ_OUT_A)
    else $error("irq a released but driving high");
  AST_OD_B: assert property (!IRQ_OUT_B_OE |-> !IRQ_OUT_B)
    else $error("irq b released but driving high");

  // main traffic seen
  cover property (wr_acc);
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property ($fell(IRQ_OUT_A));
endmodule

bind io_expander_port_irq_logic io_expander_port_irq_logic_check chk_u (.*);

//--- pin_side_model.sv
// pin-side model: resolves each pad from device drive, outside driver and pull-up
// assumes the outside driver is steered by the bench through ext_val and ext_en
`timescale 1ns/1ps
module pin_side_model (
  // clock
  input  wire logic       CORE_CLK,
  // device side of the pads
  input  wire logic [7:0] drv_out,
  input  wire logic [7:0] drv_oe,
  input  wire logic [7:0] pull_up,
  // outside driver
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // resolved level back to the device
  output logic      [7:0] pin_level
);
  logic [7:0] noise = 8'h55;

  // a floating pad must not look like a steady level
  always @(posedge CORE_CLK) begin
    noise <= ~noise;
  end

  // device drive wins, then the outside driver, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = drv_oe[i] ? drv_out[i] :
                     ext_en[i] ? ext_val[i] : pull_up[i] ? 1'b1 : noise[i];
    end
  end
endmodule

//--- tb_io_expander_port_irq_logic.sv
// self-checking bench for the expander port registers and interrupt logic
// assumes pin_side_model on both ports; byte address is four times the index
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_io_expander_port_irq_logic
  import io_expander_pkg::*;
;
  logic                  CORE_CLK        = 1'b0;
  logic                  RST_N           = 1'b0;
  logic [ADDR_WIDTH-1:0] AVS_ADDRESS     = 8'h00;
  logic                  AVS_READ        = 1'b0;
  logic                  AVS_WRITE       = 1'b0;
  logic [DATA_WIDTH-1:0] AVS_WRITEDATA   = 32'h00000000;
  logic [DATA_WIDTH-1:0] AVS_READDATA;
  logic                  AVS_WAITREQUEST;
  logic [PORT_WIDTH-1:0] PA_IN, PA_OUT, PA_OE, PA_PULLUP, PB_IN, PB_OUT, PB_OE, PB_PULLUP;
  logic                  IRQ_OUT_A, IRQ_OUT_A_OE, IRQ_OUT_B, IRQ_OUT_B_OE;
  logic [7:0]            ext_a = 8'h00, ext_b = 8'h00, ext_en = 8'hFF, rdv;
  int                    fail_count = 0, num_checks = 0;

  always #50 CORE_CLK = ~CORE_CLK;

  io_expander_port_irq_logic dut_u (.*);
  pin_side_model pin_a_u (.CORE_CLK(CORE_CLK), .drv_out(PA_OUT), .drv_oe(PA_OE),
    .pull_up(PA_PULLUP), .ext_val(ext_a), .ext_en(ext_en), .pin_level(PA_IN));
  pin_side_model pin_b_u (.CORE_CLK(CORE_CLK), .drv_out(PB_OUT), .drv_oe(PB_OE),
    .pull_up(PB_PULLUP), .ext_val(ext_b), .ext_en(ext_en), .pin_level(PB_IN));

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one bus cycle, held until waitrequest is seen low; bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h000000, d};
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rdv = AVS_READDATA[7:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK($sformatf("reg %0h", a), e, rdv)
  endtask

  // covers pin synchroniser, detection and output register
  task automatic settle;
    repeat (10) @(posedge CORE_CLK);
  endtask

  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    for (logic [7:0] a = 8'h18; a <= 8'h28; a += 8'h04) begin
      rdc(a, 8'h00);
      rdc(a + 8'h40, 8'h00);
    end
    wr(8'h04, 8'hFF);
    rdc(8'h04, 8'h00);
    wr(8'h1C, 8'hFF);
    rdc(8'h1C, 8'h00);
    // upper nibble outputs, lower nibble inputs
    wr(8'h00, 8'h0F);
    wr(8'h18, 8'hFF);
    settle;
    `CHK("pullup a", 8'h0F, PA_PULLUP)
    `CHK("oe a", 8'hF0, PA_OE)
    rdc(8'h18, 8'hFF);
    ext_en <= 8'h00;
    settle;
    rdc(8'h24, 8'h0F);
    ext_en <= 8'hFF;
    wr(8'h24, 8'hA5);
    ext_a <= 8'h03;
    rdc(8'h28, 8'hA5);
    settle;
    `CHK("out a", 8'hA5, PA_OUT)
    rdc(8'h24, 8'hA3);
    wr(8'h28, 8'h5A);
    rdc(8'h28, 8'h5A);
    settle;
    rdc(8'h24, 8'h53);
    // pin-change mode on every bit
    wr(8'h08, 8'hFF);
    settle;
    `CHK("irq a idle", 1'b1, IRQ_OUT_A)
    ext_a <= 8'h01;
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    rdc(8'h1C, 8'h02);
    wr(8'h20, 8'h00);
    wr(8'h24, 8'h5A);
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    ext_a <= 8'h00;
    settle;
    rdc(8'h20, 8'h51);
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    rdc(8'h20, 8'h50);
    rdc(8'h24, 8'h50);
    settle;
    `CHK("irq a", 1'b1, IRQ_OUT_A)
    wr(8'h28, 8'hFA);
    settle;
    `CHK("irq a", 1'b1, IRQ_OUT_A)
    // bit 0 against a default of zero
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'h01);
    ext_a <= 8'h01;
    settle;
    rdc(8'h24, 8'hF1);
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    ext_a <= 8'h00;
    settle;
    rdc(8'h20, 8'hF1);
    settle;
    `CHK("irq a", 1'b1, IRQ_OUT_A)
    // mirrored outputs, then polarity and open-drain
    wr(8'h14, 8'h40);
    wr(8'h48, 8'h01);
    ext_b <= 8'h01;
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    `CHK("irq b", 1'b0, IRQ_OUT_B)
    rdc(8'h24, 8'hF0);
    settle;
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    rdc(8'h64, 8'h01);
    settle;
    `CHK("irq a", 1'b1, IRQ_OUT_A)
    wr(8'h14, 8'h00);
    ext_b <= 8'h00;
    settle;
    `CHK("irq b", 1'b0, IRQ_OUT_B)
    `CHK("irq a", 1'b1, IRQ_OUT_A)
    wr(8'h14, 8'h02);
    settle;
    `CHK("irq b", 1'b1, IRQ_OUT_B)
    `CHK("irq a", 1'b0, IRQ_OUT_A)
    wr(8'h14, 8'h06);
    settle;
    `CHK("irq b oe", 1'b1, IRQ_OUT_B_OE)
    `CHK("irq a oe", 1'b0, IRQ_OUT_A_OE)
    rdc(8'h64, 8'h00);
    settle;
    `CHK("irq b oe", 1'b0, IRQ_OUT_B_OE)
    wr(8'h68, 8'h3C);
    settle;
    `CHK("out b", 8'h3C, PB_OUT)
    `CHK("oe b", 8'h00, PB_OE)
    conclude();
  end
endmodule
